// ### rtl/irgen_top.sv
// Initial reset generator combining oscillator loss, pin, key group and watchdog sources.
// What this block does
// - Reset from oscillation detector, reset pin, key combination or watchdog.
// - Oscillation detector holds reset until oscillator runs and when it stops.
// - High reset pin resets; must stay high 5 ms to pass noise rejector.
// - Core stays reset while pin high, runs once pin goes low.
// - All selected keys high together reset; must stay high 5 ms.
// - Key group is build choice: off, two, three or four keys ANDed.
// - Optional qualifier needs key combination held 1 to 2 seconds.
// - Watchdog runaway detection causes initial reset.
// - Reset loads step 00H, page 1H and next page pointer 1H.
// - Data memory and segment data are not initialized by reset.
`timescale 1ns/1ps

module irgen_top #(
  parameter irgen_pkg::irgen_keysel_t KEY_SEL  = irgen_pkg::IRGEN_KEY_FOUR,
  parameter bit                       QUAL_EN  = 1'b0,
  parameter int unsigned              NOISE_N  = irgen_pkg::NOISE_CYC,
  parameter int unsigned              QUAL_N   = irgen_pkg::QUAL_CYC,
  parameter int unsigned              OSC_N    = irgen_pkg::OSC_LOSS_CYC
) (
  input  wire logic                         clk_sys,       // System clock, 20 MHz.
  input  wire logic                         resetn,        // Async reset, active low.
  input  wire logic                         low_speed_osc, // Crystal oscillator output.
  input  wire logic                         reset_pin,     // External reset, active high.
  input  wire logic                         key_in_0,      // Key input 0.
  input  wire logic                         key_in_1,      // Key input 1.
  input  wire logic                         key_in_2,      // Key input 2.
  input  wire logic                         key_in_3,      // Key input 3.
  input  wire logic                         wdt_runaway,   // Watchdog runaway, same clock.
  output logic                              core_reset,    // Combined initial reset.
  output irgen_pkg::irgen_core_init_t       core_init      // Values the core loads.
);

  typedef struct packed {
    logic [2:0]            osc_sync;
    logic [2:0]            pin_sync;
    logic [2:0]            key_sync;
    logic                  osc_prev;
    logic [1:0]            osc_edges;
    logic [31:0]           osc_cnt;
    logic [31:0]           pin_cnt;
    logic [31:0]           key_cnt;
    logic [31:0]           qual_cnt;
    logic                  osc_dead;
    logic                  pin_rst;
    logic                  key_rst;
    logic                  wdt_rst;
    logic                  core_reset;
    irgen_pkg::irgen_core_init_t core_init;
  } irgen_state_t;

  irgen_state_t st;
  irgen_state_t next_st;

  // Counter that runs while its condition holds and restarts when it drops.
  function automatic logic [31:0] irgen_count(input logic cond, input logic [31:0] cnt,
                                              input logic [31:0] lim);
    if (!cond) begin
      irgen_count = 32'h0;
    end else if (cnt < lim) begin
      irgen_count = cnt + 32'h1;
    end else begin
      irgen_count = cnt;
    end
  endfunction : irgen_count

  // The group is combined before the synchroniser, so one stage set serves all keys.
  logic key_all;
  always_comb begin
    case (KEY_SEL)
      irgen_pkg::IRGEN_KEY_TWO:   key_all = key_in_0 & key_in_1;
      irgen_pkg::IRGEN_KEY_THREE: key_all = key_in_0 & key_in_1 & key_in_2;
      irgen_pkg::IRGEN_KEY_FOUR:  key_all = key_in_0 & key_in_1 & key_in_2 & key_in_3;
      default:                    key_all = 1'b0;
    endcase
  end

  logic pin_hi;
  logic key_hi;
  logic osc_edge;
  logic key_ok;

  always_comb begin
    next_st  = st;
    next_st.osc_sync = {st.osc_sync[1:0], low_speed_osc};
    next_st.pin_sync = {st.pin_sync[1:0], reset_pin};
    next_st.key_sync = {st.key_sync[1:0], key_all};
    // Only the agreeing second and third stages are looked at.
    pin_hi   = st.pin_sync[1] & st.pin_sync[2];
    key_hi   = st.key_sync[1] & st.key_sync[2];
    osc_edge = (st.osc_sync[1] == st.osc_sync[2]) && (st.osc_sync[2] != st.osc_prev);
    if (st.osc_sync[1] == st.osc_sync[2]) begin
      next_st.osc_prev = st.osc_sync[2];
    end
    // Oscillator loss: no transition within the window means it stopped.
    next_st.osc_cnt  = irgen_count(!osc_edge, st.osc_cnt, 32'(OSC_N));
    // A pin stuck at either level gives at most one edge, so two are needed to run.
    if (next_st.osc_cnt >= 32'(OSC_N)) begin
      next_st.osc_edges = 2'h0;
    end else if (osc_edge && (st.osc_edges < 2'(irgen_pkg::OSC_RUN_EDGES))) begin
      next_st.osc_edges = st.osc_edges + 2'h1;
    end
    next_st.osc_dead = (next_st.osc_cnt >= 32'(OSC_N))
                       || (next_st.osc_edges < 2'(irgen_pkg::OSC_RUN_EDGES));
    // Noise rejectors on pin and keys. The window is counted on clk_sys, so its length
    // follows NOISE_N and not the crystal's frequency.
    next_st.pin_cnt  = irgen_count(pin_hi, st.pin_cnt, 32'(NOISE_N));
    next_st.pin_rst  = (next_st.pin_cnt >= 32'(NOISE_N));
    next_st.key_cnt  = irgen_count(key_hi, st.key_cnt, 32'(NOISE_N));
    key_ok           = (next_st.key_cnt >= 32'(NOISE_N));
    next_st.qual_cnt = irgen_count(key_ok && QUAL_EN, st.qual_cnt, 32'(QUAL_N));
    next_st.key_rst  = QUAL_EN ? (next_st.qual_cnt >= 32'(QUAL_N)) : key_ok;
    next_st.wdt_rst  = wdt_runaway;
    next_st.core_reset = st.osc_dead | st.pin_rst | st.key_rst | st.wdt_rst;
    // Only the core's start values are produced; memory is left alone.
    next_st.core_init.pc_step           = irgen_pkg::PC_STEP_INIT;
    next_st.core_init.pc_page           = irgen_pkg::PC_PAGE_INIT;
    next_st.core_init.next_page_pointer = irgen_pkg::NEXT_PAGE_PTR_INIT;
    next_st.core_init.irq_en            = irgen_pkg::IRQ_EN_INIT;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // Power-on counts as no oscillation yet, so reset is held.
      st                               <= '0;
      st.osc_dead                      <= 1'b1;
      st.core_reset                    <= 1'b1;
      st.core_init.pc_step             <= irgen_pkg::PC_STEP_INIT;
      st.core_init.pc_page             <= irgen_pkg::PC_PAGE_INIT;
      st.core_init.next_page_pointer   <= irgen_pkg::NEXT_PAGE_PTR_INIT;
      st.core_init.irq_en              <= irgen_pkg::IRQ_EN_INIT;
    end else begin
      st <= next_st;
    end
  end

  assign core_reset = st.core_reset;
  assign core_init  = st.core_init;

  chk_pin_holds_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    st.pin_rst |-> ##1 core_reset)
    else $error("Reset pin active but core not in reset.");
  chk_wdt_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    wdt_runaway |-> ##2 core_reset)
    else $error("Watchdog runaway did not reset the core.");
  chk_short_pin: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(st.pin_rst) |-> st.pin_cnt == 32'(NOISE_N))
    else $error("Pin reset asserted before noise window elapsed.");
  chk_init_values: assert property (@(posedge clk_sys) disable iff (!resetn)
    core_init.pc_page == 4'h1 && core_init.next_page_pointer == 4'h1
    && core_init.pc_step == 8'h00)
    else $error("Core start values wrong.");
  chk_irq_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    core_init.irq_en == 1'b0)
    else $error("Interrupt enable not cleared.");
  chk_key_group: assert property (@(posedge clk_sys) disable iff (!resetn)
    (KEY_SEL == irgen_pkg::IRGEN_KEY_OFF) |-> !st.key_rst)
    else $error("Key reset active while group disabled.");
  chk_osc_loss: assert property (@(posedge clk_sys) disable iff (!resetn)
    st.osc_dead |-> ##1 core_reset)
    else $error("Oscillator loss did not reset the core.");
  chk_counter_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
    !st.pin_sync[2] |-> ##1 st.pin_cnt == 32'h0)
    else $error("Noise counter did not restart.");

  // The key combination path mirrors the pin path behind its own rejector.
  chk_key_holds_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    st.key_rst |-> ##1 core_reset)
    else $error("Key combination active but core not in reset.");

  chk_key_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
    !QUAL_EN && key_hi && st.key_cnt == 32'(NOISE_N) - 32'h1 |-> ##1 st.key_rst)
    else $error("Key combination held through window but not taken.");

  chk_qual_window: assert property (@(posedge clk_sys) disable iff (!resetn)
    st.key_rst |-> (QUAL_EN ? (st.qual_cnt == 32'(QUAL_N)) : (st.key_cnt == 32'(NOISE_N))))
    else $error("Key reset asserted before its window elapsed.");

  chk_key_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
    !st.key_sync[2] |-> ##1 st.key_cnt == 32'h0)
    else $error("Key noise counter did not restart.");

  chk_pin_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
    pin_hi && st.pin_cnt == 32'(NOISE_N) - 32'h1 |-> ##1 st.pin_rst)
    else $error("Reset pin held through window but not taken.");

  chk_pin_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    st.pin_rst && !st.pin_sync[2] |-> ##1 !st.pin_rst)
    else $error("Pin reset kept after the pin went low.");

  // Watchdog requests are taken as they come, with no filtering.
  chk_wdt_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
    wdt_runaway |-> ##1 st.wdt_rst)
    else $error("Watchdog request not captured.");

  chk_wdt_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    !wdt_runaway |-> ##1 !st.wdt_rst)
    else $error("Watchdog request held after it ended.");

  chk_reset_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    !st.osc_dead && !st.pin_rst && !st.key_rst && !st.wdt_rst |-> ##1 !core_reset)
    else $error("Core held in reset with no source active.");

  // The oscillator watch restarts on every edge and needs two edges to clear.
  chk_osc_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
    osc_edge |-> ##1 st.osc_cnt == 32'h0)
    else $error("Oscillator loss counter did not restart on an edge.");

  chk_osc_timeout: assert property (@(posedge clk_sys) disable iff (!resetn)
    !osc_edge && st.osc_cnt == 32'(OSC_N) - 32'h1 |-> ##1 st.osc_dead)
    else $error("Oscillator loss not flagged after the window.");

  chk_osc_run_edges: assert property (@(posedge clk_sys) disable iff (!resetn)
    !osc_edge && st.osc_edges == 2'h0 |-> ##1 st.osc_dead)
    else $error("Oscillator taken as running without edges.");

  chk_init_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
    $stable(core_init))
    else $error("Core start values changed.");

endmodule : irgen_top

// ### rtl/irgen_pkg.sv
// Package with constants and carrier types for the initial reset generator.
package irgen_pkg;

  // Clock and timing figures.
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned NOISE_MS        = 5;
  localparam int unsigned QUAL_MS         = 1500;
  localparam int unsigned NOISE_CYC       = (CLK_HZ / 1000) * NOISE_MS;
  localparam int unsigned QUAL_CYC        = (CLK_HZ / 1000) * QUAL_MS;
  localparam int unsigned OSC_LOSS_CYC    = 4096;
  localparam int unsigned OSC_RUN_EDGES   = 2;
  localparam int unsigned CNT_W           = 32;

  // Core values loaded on initial reset.
  localparam logic [7:0] PC_STEP_INIT     = 8'h00;
  localparam logic [3:0] PC_PAGE_INIT     = 4'h1;
  localparam logic [3:0] NEXT_PAGE_PTR_INIT = 4'h1;
  localparam logic       IRQ_EN_INIT      = 1'h0;

  // Build-time key group choices.
  typedef enum logic [1:0] {
    IRGEN_KEY_OFF,
    IRGEN_KEY_TWO,
    IRGEN_KEY_THREE,
    IRGEN_KEY_FOUR
  } irgen_keysel_t;

  // Values handed to the core.
  typedef struct packed {
    logic [7:0] pc_step;
    logic [3:0] pc_page;
    logic [3:0] next_page_pointer;
    logic       irq_en;
  } irgen_core_init_t;

endpackage : irgen_pkg

// ### testbench/irgen_far_model.sv
// Far-side model: crystal clock, external reset pin and key lines.
`timescale 1ns/1ps
module irgen_far_model (
  input  wire logic       clk_sys,       // System clock.
  output logic            low_speed_osc, // Crystal clock.
  output logic            reset_pin,     // External reset.
  output logic      [3:0] keys           // Key lines.
);
  logic     osc_run = 1'b0;
  int       ph = 0;
  initial begin
    low_speed_osc = 1'b0;
    reset_pin = 1'b0;
    keys = 4'h0;
  end
  // A stopped crystal holds its last level; only toggling counts as running.
  always @(posedge clk_sys) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (osc_run && ph == 2) low_speed_osc <= #2 ~low_speed_osc;
  end
  task automatic hold_pin(input int n);
    @(posedge clk_sys);
    #2 reset_pin = 1'b1;
    repeat (n) @(posedge clk_sys);
    #2 reset_pin = 1'b0;
  endtask : hold_pin
  task automatic press(input logic [3:0] pat, input int n);
    @(posedge clk_sys);
    #2 keys = pat;
    repeat (n) @(posedge clk_sys);
    #2 keys = 4'h0;
  endtask : press
endmodule : irgen_far_model

// ### testbench/tb.sv
// Testbench for the initial reset generator.
`timescale 1ns/1ps
module tb;
  logic                        clk_sys = 1'b0;
  logic                        resetn = 1'b0;
  logic                        wdt_runaway = 1'b0;
  logic                        core_reset;
  irgen_pkg::irgen_core_init_t core_init;
  logic                        lso;
  logic                        rpin;
  logic [3:0]                  keys;
  logic [3:0]                  pat;
  int                          bad_count = 0;
  int                          samples_checked = 0;
  int                          seed = 32'h030c03bc;
  irgen_pkg::irgen_core_init_t exp_q[$];
  localparam irgen_pkg::irgen_core_init_t INIT = {8'h00, 4'h1, 4'h1, 1'h0};
  initial forever #25 clk_sys = ~clk_sys;
  irgen_far_model irgen_far_model_inst (.clk_sys(clk_sys), .low_speed_osc(lso),
    .reset_pin(rpin), .keys(keys));
  irgen_top #(.NOISE_N(8), .QUAL_N(16), .OSC_N(16)) irgen_top_inst (.clk_sys(clk_sys),
    .resetn(resetn), .low_speed_osc(lso), .reset_pin(rpin), .key_in_0(keys[0]),
    .key_in_1(keys[1]), .key_in_2(keys[2]), .key_in_3(keys[3]),
    .wdt_runaway(wdt_runaway), .core_reset(core_reset), .core_init(core_init));
  task automatic check_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check_bit
  task automatic check_init(input irgen_pkg::irgen_core_init_t got);
    samples_checked++;
    if (exp_q.size() == 0 || got !== exp_q[0]) begin
      bad_count++;
      $display("CHECK FAILED %0t unexpected reset or load value", $time);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  endtask : check_init
  task automatic wait_for(input logic v, input int lim);
    int k;
    for (k = 0; k < lim && core_reset !== v; k++) begin
      @(posedge clk_sys);
      #1;
    end
    check_bit(core_reset, v, "reset level not reached in time");
  endtask : wait_for
  task automatic test_done;
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  always @(posedge core_reset) if (resetn) begin
    #1 check_init(core_init);
  end
  initial begin
    #1000000 bad_count++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #2 resetn = 1'b1;
    repeat (20) @(posedge clk_sys);
    check_bit(core_reset, 1'b1, "released before crystal ran");
    irgen_far_model_inst.osc_run = 1'b1;
    wait_for(1'b0, 30);
    irgen_far_model_inst.hold_pin(4);
    repeat (20) @(posedge clk_sys);
    check_bit(core_reset, 1'b0, "short pin pulse accepted");
    exp_q.push_back(INIT);
    fork
      irgen_far_model_inst.hold_pin(30);
      begin
        repeat (27) @(posedge clk_sys);
        #1;
        check_bit(core_reset, 1'b1, "reset dropped while pin high");
      end
    join
    wait_for(1'b0, 12);
    for (int i = 0; i < 8; i++) begin
      pat = 4'($random(seed));
      if (pat == 4'hf) pat = 4'h7;
      irgen_far_model_inst.press(pat, 14);
      check_bit(core_reset, 1'b0, "partial key group reset");
    end
    exp_q.push_back(INIT);
    irgen_far_model_inst.press(4'hf, 20);
    wait_for(1'b0, 12);
    exp_q.push_back(INIT);
    @(posedge clk_sys);
    #2 wdt_runaway = 1'b1;
    @(posedge clk_sys);
    #2 wdt_runaway = 1'b0;
    repeat (4) @(posedge clk_sys);
    wait_for(1'b0, 12);
    exp_q.push_back(INIT);
    irgen_far_model_inst.osc_run = 1'b0;
    wait_for(1'b1, 40);
    irgen_far_model_inst.osc_run = 1'b1;
    wait_for(1'b0, 30);
    check_bit(exp_q.size() == 0, 1'b1, "expected reset missing");
    test_done;
  end
endmodule : tb
